/* src/sbl_consts.svh */
`ifndef SBL_CONSTS_SVH
`define SBL_CONSTS_SVH

// ****************************************************************
// Framing bytes and packet lengths.
// ****************************************************************
`define SBL_ACK 8'hcc
`define SBL_NAK 8'h33
`define SBL_SYNC 8'h55
`define SBL_SYNC_LAST 2'h1
`define SBL_LEN_MIN 8'h03
`define SBL_LEN_RUN 8'h07
`define SBL_LEN_DL 8'h0b
`define SBL_LEN_MAX 8'h0b
`define SBL_OVH 8'h03
`define SBL_HDR 8'h02
`define SBL_PAY_MAX 8'h09
`define SBL_RSP_LEN 8'h03
`define SBL_DATA_POS 8'h01

// ****************************************************************
// Command codes and status codes.
// ****************************************************************
`define SBL_CMD_PING 8'h20
`define SBL_CMD_DL 8'h21
`define SBL_CMD_RUN 8'h22
`define SBL_CMD_QRY 8'h23
`define SBL_CMD_SEND 8'h24
`define SBL_CMD_RST 8'h25
`define SBL_ST_OK 8'h40
`define SBL_ST_BADCMD 8'h41
`define SBL_ST_BADARG 8'h42
`define SBL_ST_FLASH 8'h43

`endif

/* src/sbl_pkg.sv */
// ****************************************************************
// Types shared by the loader.
// ****************************************************************
package sbl_pkg;
    typedef enum logic [12:0] {
        ST_IDLE = 13'h0001,
        ST_SUM = 13'h0002,
        ST_DATA = 13'h0004,
        ST_CHECK = 13'h0008,
        ST_EXEC = 13'h0010,
        ST_ERASE = 13'h0020,
        ST_PROG = 13'h0040,
        ST_ACK = 13'h0080,
        ST_RSP_LEN = 13'h0100,
        ST_RSP_SUM = 13'h0200,
        ST_RSP_DATA = 13'h0400,
        ST_HACK = 13'h0800,
        ST_LAUNCH = 13'h1000
    } state_t;
    typedef enum logic [1:0] {
        PORT_NONE = 2'b00,
        PORT_UART = 2'b01,
        PORT_SSI = 2'b10
    } port_t;
endpackage : sbl_pkg

/* src/serial_loader.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbl_consts.svh"

// ****************************************************************
// Transmit FIFO.
// ****************************************************************
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    logic [WIDTH-1:0] mem_q [0:DEPTH-1];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // Full and empty come straight from the fill count.
    assign in_ready = cnt_q != FULL;
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rd_q];

    // Pointers wrap at the last slot so any depth works.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else if (ce)
        begin
            if (push)
                wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
            if (pop)
                rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage needs no reset; empty slots are never read out.
    always_ff @(posedge clk)
    begin
        if (ce && push)
            mem_q[wr_q] <= in_data;
    end
endmodule : byte_fifo

// ****************************************************************
// Packet engine.
// ****************************************************************
module serial_loader
    import sbl_pkg::*;
#(
    parameter logic [32:0] FLASH_BYTES = 33'h0_0001_0000,
    parameter int TX_DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic uart_rx_valid,
    input wire logic [7:0] uart_rx_data,
    input wire logic ssi_rx_valid,
    input wire logic [7:0] ssi_rx_data,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic tx_on_ssi,
    output logic flash_req,
    output logic flash_op_prog,
    output logic [31:0] flash_addr,
    output logic [31:0] flash_size,
    output logic [7:0] flash_wdata,
    input wire logic flash_done,
    input wire logic flash_err,
    output logic run_req,
    output logic [31:0] run_addr,
    output logic soft_reset_req
);
    function automatic logic [31:0] be32(input logic [7:0] a, input logic [7:0] b,
                                         input logic [7:0] c, input logic [7:0] d);
        return {a, b, c, d};
    endfunction : be32

    logic rst_s1_q;
    logic rst_n;
    state_t state_q;
    state_t after_q;
    port_t port_q;
    logic synced_q;
    logic [1:0] sync_cnt_q;
    logic [7:0] len_q;
    logic [7:0] sum_exp_q;
    logic [7:0] sum_q;
    logic [7:0] cnt_q;
    logic [7:0] idx_q;
    logic [7:0] pay_q [0:`SBL_PAY_MAX-1];
    logic [7:0] ack_byte_q;
    logic [7:0] status_q;
    logic prog_active_q;
    logic [31:0] prog_addr_q;
    logic [31:0] remain_q;
    logic launch_run_q;
    logic [31:0] run_addr_q;
    logic run_q;
    logic soft_q;

    // ****************************************************************
    // Reset release through two flip-flops.
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // ****************************************************************
    // Port selection and byte intake.
    // ****************************************************************
    // Until a port is locked the async port wins a tie; afterwards the other is deaf.
    wire uart_take = uart_rx_valid && (port_q != PORT_SSI);
    wire ssi_take = ssi_rx_valid && (port_q != PORT_UART) && !uart_take;
    wire rx_fire = uart_take || ssi_take;
    wire [7:0] rx_byte = uart_take ? uart_rx_data : ssi_rx_data;
    wire on_uart = (port_q == PORT_UART) || (port_q == PORT_NONE && uart_take);
    wire need_sync = on_uart && !synced_q;
    // Padding zeros between packets are simply skipped.
    wire rx_start = rx_fire && rx_byte != 8'h00 && !need_sync;

    // Packet checks; the sum is eight bits wide so it wraps naturally.
    wire [7:0] sum_next = sum_q + rx_byte;
    wire pay_last = (cnt_q + `SBL_OVH) == len_q;
    wire pkt_good = (sum_q == sum_exp_q) && (len_q <= `SBL_LEN_MAX);
    wire [7:0] cmd = pay_q[0];
    wire [31:0] arg_a = be32(pay_q[1], pay_q[2], pay_q[3], pay_q[4]);
    wire [31:0] arg_b = be32(pay_q[5], pay_q[6], pay_q[7], pay_q[8]);
    wire range_ok = ({1'b0, arg_a} + {1'b0, arg_b} <= FLASH_BYTES) && arg_b != '0;
    wire have_byte = (idx_q + `SBL_HDR) < len_q && remain_q != '0;

    // ****************************************************************
    // Transmit path.
    // ****************************************************************
    logic push_valid;
    logic [7:0] push_data;
    logic push_ready;
    wire push_ok = push_valid && push_ready;

    // One byte is offered to the FIFO in each answering state.
    assign push_valid = state_q inside {ST_ACK, ST_RSP_LEN, ST_RSP_SUM, ST_RSP_DATA};
    assign push_data = (state_q == ST_ACK) ? ack_byte_q :
                       (state_q == ST_RSP_LEN) ? `SBL_RSP_LEN : status_q;

    byte_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx_fifo (
        .clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_data),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(tx_data)
    );

    // Handshake with the flash controller is a held request ended by done.
    assign flash_req = (state_q == ST_ERASE) || (state_q == ST_PROG && have_byte);
    assign flash_op_prog = state_q == ST_PROG;
    assign flash_addr = prog_addr_q;
    assign flash_size = remain_q;
    assign flash_wdata = pay_q[idx_q[3:0]];
    // The clocked port's shim runs the mode-3 frame and its padding; this block only steers replies.
    assign tx_on_ssi = port_q == PORT_SSI;
    assign run_req = run_q;
    assign run_addr = run_addr_q;
    assign soft_reset_req = soft_q;

    // ****************************************************************
    // Port lock and async sync pattern.
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_q <= PORT_NONE;
            synced_q <= 1'b0;
            sync_cnt_q <= '0;
        end
        else if (ce)
        begin
            if (port_q == PORT_NONE && rx_fire && (uart_take || rx_byte != 8'h00))
                port_q <= uart_take ? PORT_UART : PORT_SSI;
            if (state_q == ST_IDLE && rx_fire && need_sync)
            begin
                // Any other byte restarts the pattern, so the host may resend it.
                sync_cnt_q <= (rx_byte == `SBL_SYNC) ? sync_cnt_q + 1'b1 : '0;
                if (rx_byte == `SBL_SYNC && sync_cnt_q == `SBL_SYNC_LAST)
                    synced_q <= 1'b1;
            end
        end
    end

    // Payload bytes land in the buffer; overlong packets keep only the head.
    always_ff @(posedge ref_clk)
    begin
        if (ce && state_q == ST_DATA && rx_fire && cnt_q < `SBL_PAY_MAX)
            pay_q[cnt_q[3:0]] <= rx_byte;
    end

    // ****************************************************************
    // Main sequencer.
    // ****************************************************************
    // Flash commands run before their acknowledge, so a long erase delays the answer.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            after_q <= ST_IDLE;
            len_q <= '0;
            sum_exp_q <= '0;
            sum_q <= '0;
            cnt_q <= '0;
            idx_q <= '0;
            ack_byte_q <= `SBL_ACK;
            status_q <= `SBL_ST_OK;
            prog_active_q <= 1'b0;
            prog_addr_q <= '0;
            remain_q <= '0;
            launch_run_q <= 1'b0;
            run_addr_q <= '0;
            run_q <= 1'b0;
            soft_q <= 1'b0;
        end
        else if (ce)
        begin
            run_q <= 1'b0;
            soft_q <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (rx_fire && need_sync && rx_byte == `SBL_SYNC && sync_cnt_q == `SBL_SYNC_LAST)
                    begin
                        ack_byte_q <= `SBL_ACK;
                        after_q <= ST_IDLE;
                        state_q <= ST_ACK;
                    end
                    else if (rx_start)
                    begin
                        len_q <= rx_byte;
                        after_q <= ST_IDLE;
                        ack_byte_q <= `SBL_NAK;
                        state_q <= (rx_byte < `SBL_LEN_MIN) ? ST_ACK : ST_SUM;
                    end
                end
                ST_SUM:
                    if (rx_fire)
                    begin
                        sum_exp_q <= rx_byte;
                        sum_q <= '0;
                        cnt_q <= '0;
                        state_q <= ST_DATA;
                    end
                ST_DATA:
                    if (rx_fire)
                    begin
                        sum_q <= sum_next;
                        cnt_q <= cnt_q + 1'b1;
                        if (pay_last)
                            state_q <= ST_CHECK;
                    end
                ST_CHECK:
                begin
                    ack_byte_q <= pkt_good ? `SBL_ACK : `SBL_NAK;
                    after_q <= ST_IDLE;
                    // A bad packet goes straight to NAK and touches nothing.
                    state_q <= pkt_good ? ST_EXEC : ST_ACK;
                end
                ST_EXEC:
                begin
                    state_q <= ST_ACK;
                    case (cmd)
                        `SBL_CMD_PING:
                            status_q <= `SBL_ST_OK;
                        `SBL_CMD_QRY:
                            after_q <= ST_RSP_LEN;
                        `SBL_CMD_DL:
                            if (len_q == `SBL_LEN_DL && range_ok)
                            begin
                                prog_addr_q <= arg_a;
                                remain_q <= arg_b;
                                state_q <= ST_ERASE;
                            end
                            else
                            begin
                                status_q <= `SBL_ST_BADARG;
                                prog_active_q <= 1'b0;
                            end
                        `SBL_CMD_SEND:
                            if (prog_active_q)
                            begin
                                idx_q <= `SBL_DATA_POS;
                                status_q <= `SBL_ST_OK;
                                state_q <= ST_PROG;
                            end
                            else
                                status_q <= `SBL_ST_BADCMD;
                        `SBL_CMD_RUN:
                            if (len_q == `SBL_LEN_RUN)
                            begin
                                run_addr_q <= arg_a;
                                launch_run_q <= 1'b1;
                                status_q <= `SBL_ST_OK;
                                after_q <= ST_LAUNCH;
                            end
                            else
                                status_q <= `SBL_ST_BADARG;
                        `SBL_CMD_RST:
                            if (len_q == `SBL_LEN_MIN)
                            begin
                                launch_run_q <= 1'b0;
                                after_q <= ST_LAUNCH;
                            end
                            else
                                status_q <= `SBL_ST_BADARG;
                        default:
                            status_q <= `SBL_ST_BADCMD;
                    endcase
                end
                ST_ERASE:
                    if (flash_done)
                    begin
                        status_q <= flash_err ? `SBL_ST_FLASH : `SBL_ST_OK;
                        prog_active_q <= !flash_err;
                        state_q <= ST_ACK;
                    end
                ST_PROG:
                    if (!have_byte)
                    begin
                        if (remain_q == '0)
                            prog_active_q <= 1'b0;
                        state_q <= ST_ACK;
                    end
                    else if (flash_done)
                    begin
                        prog_addr_q <= prog_addr_q + 32'h1;
                        remain_q <= remain_q - 32'h1;
                        idx_q <= idx_q + 1'b1;
                        if (flash_err)
                        begin
                            status_q <= `SBL_ST_FLASH;
                            state_q <= ST_ACK;
                        end
                    end
                ST_ACK:
                    if (push_ok)
                        state_q <= after_q;
                ST_RSP_LEN:
                    if (push_ok)
                        state_q <= ST_RSP_SUM;
                ST_RSP_SUM:
                    if (push_ok)
                        state_q <= ST_RSP_DATA;
                ST_RSP_DATA:
                    if (push_ok)
                        state_q <= ST_HACK;
                ST_HACK:
                    // Either answer closes the reply; a NAK means the host asks again.
                    if (rx_start)
                        state_q <= ST_IDLE;
                ST_LAUNCH:
                    // The jump waits until the acknowledge has left the FIFO.
                    if (!tx_valid)
                    begin
                        run_q <= launch_run_q;
                        soft_q <= !launch_run_q;
                        state_q <= ST_IDLE;
                    end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_ack_code;
        state_q == ST_ACK && push_ok |-> push_data == `SBL_ACK || push_data == `SBL_NAK;
    endproperty
    a_ack_code: assert property (p_ack_code) else $error("bad acknowledge byte");

    property p_bad_sum_nak;
        ce && state_q == ST_CHECK && sum_q != sum_exp_q |=> state_q == ST_ACK && ack_byte_q == `SBL_NAK;
    endproperty
    a_bad_sum_nak: assert property (p_bad_sum_nak) else $error("bad sum not refused");

    property p_len_count;
        state_q == ST_CHECK |-> cnt_q + `SBL_HDR == len_q;
    endproperty
    a_len_count: assert property (p_len_count) else $error("payload count off");

    property p_nak_keeps_addr;
        ce && state_q == ST_CHECK && !pkt_good |=> $stable(prog_addr_q) [*2];
    endproperty
    a_nak_keeps_addr: assert property (p_nak_keeps_addr) else $error("address moved on NAK");

    property p_erase_first;
        ce && state_q == ST_EXEC && cmd == `SBL_CMD_DL && len_q == `SBL_LEN_DL && range_ok
            |=> flash_req && !flash_op_prog;
    endproperty
    a_erase_first: assert property (p_erase_first) else $error("no erase before ack");

    // A frozen clock enable holds the pulse high, so only its first cycle is judged.
    property p_launch_after_tx;
        $rose(run_req) || $rose(soft_reset_req) |-> $past(state_q) == ST_LAUNCH && !$past(tx_valid);
    endproperty
    a_launch_after_tx: assert property (p_launch_after_tx) else $error("launch before ack sent");

    property p_rsp_len;
        state_q == ST_RSP_LEN |-> push_data == `SBL_RSP_LEN;
    endproperty
    a_rsp_len: assert property (p_rsp_len) else $error("status packet length wrong");

    property p_port_lock;
        port_q != PORT_NONE |=> $stable(port_q);
    endproperty
    a_port_lock: assert property (p_port_lock) else $error("port lock changed");

    property p_prog_end;
        ce && state_q == ST_PROG && !have_byte && remain_q == '0 |=> !prog_active_q;
    endproperty
    a_prog_end: assert property (p_prog_end) else $error("programming did not end");

    c_ping: cover property (state_q == ST_EXEC && cmd == `SBL_CMD_PING ##1 state_q == ST_ACK);
    c_erase: cover property (state_q == ST_ERASE && flash_done);
    c_run: cover property (run_req);
    c_query: cover property (state_q == ST_HACK && rx_start);
endmodule : serial_loader
`default_nettype wire

/* dv/flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Flash controller stand-in.
// ****************************************************************
module flash_model (
    input wire logic clk,
    input wire logic req,
    output logic done,
    output logic err
);
    int wait_n = 0;
    initial done = 1'b0;
    // Latency varies from one to three cycles so both quick and slow answers occur.
    always @(posedge clk)
    begin
        if (done || !req)
            done <= 1'b0;
        else if (wait_n == 0)
        begin
            done <= 1'b1;
            wait_n <= $urandom % 3;
        end
        else
            wait_n <= wait_n - 1;
    end
    // Failures are not modelled, so every operation succeeds.
    assign err = 1'b0;
endmodule : flash_model
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbl_consts.svh"
// ****************************************************************
// Host-side bench with a queue model of the expected traffic.
// ****************************************************************
module testbench;
    logic ref_clk = 1'b0, rst_b = 1'b0, uart_v = 1'b0, ssi_v = 1'b0, tx_ready = 1'b0;
    logic ce = 1'b1, use_ssi = 1'b0;
    logic [7:0] uart_d = 8'h00, ssi_d = 8'h00, tx_data, flash_wdata;
    logic tx_valid, tx_on_ssi, flash_req, flash_op_prog, flash_done, flash_err, run_req, soft_reset_req;
    logic [31:0] flash_addr, flash_size, run_addr, next_addr = 32'h0000_0100, left = 32'h0;
    logic [7:0] exp_tx[$], pay[$];
    logic [72:0] exp_fl[$];
    int mismatches = 0, n_tests = 0, n_runs = 0, n_rsts = 0;
    always #20 ref_clk = ~ref_clk;
    serial_loader #(.FLASH_BYTES(33'h0_0001_0000), .TX_DEPTH(8)) serial_loader_i (.ref_clk(ref_clk),
        .rst_b(rst_b), .ce(ce), .uart_rx_valid(uart_v), .uart_rx_data(uart_d), .ssi_rx_valid(ssi_v),
        .ssi_rx_data(ssi_d), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .tx_on_ssi(tx_on_ssi),
        .flash_req(flash_req), .flash_op_prog(flash_op_prog), .flash_addr(flash_addr), .flash_size(flash_size),
        .flash_wdata(flash_wdata), .flash_done(flash_done), .flash_err(flash_err), .run_req(run_req),
        .run_addr(run_addr), .soft_reset_req(soft_reset_req));
    flash_model flash_model_i (.clk(ref_clk), .req(flash_req), .done(flash_done), .err(flash_err));
    task check(input logic [72:0] seen, input logic [72:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task tally_and_finish;
        $display("mismatches %0d, comparisons %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    // Sink stalls at random; every nonzero byte taken and every flash operation is matched in order.
    // Nothing counts as taken while the clock enable freezes the design.
    always @(posedge ref_clk)
    begin
        tx_ready <= ($urandom % 4) != 0;
        if (ce && tx_valid && tx_ready && tx_data != 8'h00)
            check(tx_data, exp_tx.size() ? exp_tx.pop_front() : 8'h00);
        if (ce && flash_req && flash_done)
            check({flash_op_prog, flash_op_prog ? flash_wdata : 8'h00, flash_addr, flash_size},
                  exp_fl.size() ? exp_fl.pop_front() : '1);
        if (ce && run_req)
            n_runs++;
        if (ce && run_req)
            check(run_addr, 32'h0000_1234);
        if (ce && soft_reset_req)
            n_rsts++;
    end
    task put(input logic [7:0] b);
        @(posedge ref_clk);
        uart_v <= !use_ssi;
        ssi_v <= use_ssi;
        uart_d <= b;
        ssi_d <= b;
    endtask : put
    task drop;
        @(posedge ref_clk);
        uart_v <= 1'b0;
        ssi_v <= 1'b0;
    endtask : drop
    // Bounded wait until all expected traffic has been seen.
    task drain;
        int k;
        for (k = 0; k < 3000 && (exp_tx.size() || exp_fl.size()); k++)
        begin
            ce <= ($urandom % 4) != 0;
            @(posedge ref_clk);
        end
        ce <= 1'b1;
        if (k == 3000)
        begin
            mismatches++;
            $display("wrong value at %0t: traffic missing", $time);
            tally_and_finish();
        end
        repeat (6) @(posedge ref_clk);
    endtask : drain
    task send_pkt(input logic bad, input int rsp);
        logic [7:0] sum;
        sum = 8'h00;
        foreach (pay[i]) sum += pay[i];
        exp_tx.push_back(bad ? `SBL_NAK : `SBL_ACK);
        if (rsp >= 0)
            exp_tx = {exp_tx, `SBL_RSP_LEN, 8'(rsp), 8'(rsp)};
        put(8'(pay.size() + 2));
        put(sum ^ {7'h00, bad});
        foreach (pay[i]) put(pay[i]);
        drop();
        drain();
    endtask : send_pkt
    // The host pads with a zero before its answer to the status packet.
    task query(input logic [7:0] s);
        pay = {`SBL_CMD_QRY};
        send_pkt(1'b0, int'(s));
        put(8'h00);
        put(`SBL_ACK);
        drop();
        repeat (4) @(posedge ref_clk);
    endtask : query
    task dl(input logic [63:0] arg, input logic good);
        pay = {`SBL_CMD_DL};
        for (int i = 7; i >= 0; i--) pay.push_back(arg[8*i +: 8]);
        if (good)
        begin
            exp_fl.push_back({1'b0, 8'h00, arg});
            left = arg[31:0];
        end
        send_pkt(1'b0, -1);
    endtask : dl
    task send_data(input int n, input int nprog, input logic bad);
        logic [7:0] b;
        pay = {`SBL_CMD_SEND};
        for (int i = 0; i < n; i++)
        begin
            b = $urandom;
            pay.push_back(b);
            if (i < nprog)
                exp_fl.push_back({1'b1, b, next_addr + 32'(i), left - 32'(i)});
        end
        if (!bad)
        begin
            next_addr += 32'(nprog);
            left -= 32'(nprog);
        end
        send_pkt(bad, -1);
    endtask : send_data
    // Main sequence.
    initial
    begin
        void'($urandom(51));
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
        exp_tx.push_back(`SBL_ACK);
        put(`SBL_SYNC);
        put(`SBL_SYNC);
        drop();
        drain();
        use_ssi = 1'b1;
        put(8'h03);
        put(`SBL_CMD_PING);
        put(`SBL_CMD_PING);
        drop();
        use_ssi = 1'b0;
        repeat (20) @(posedge ref_clk);
        check(tx_on_ssi, 1'b0);
        pay = {`SBL_CMD_PING};
        send_pkt(1'b0, -1);
        query(`SBL_ST_OK);
        send_pkt(1'b1, -1);
        pay = {8'h30};
        send_pkt(1'b0, -1);
        query(`SBL_ST_BADCMD);
        send_data(1, 0, 1'b0);
        query(`SBL_ST_BADCMD);
        dl({32'hffff_0000, 32'h0000_0010}, 1'b0);
        query(`SBL_ST_BADARG);
        dl({32'h0000_0100, 32'h0000_000a}, 1'b1);
        query(`SBL_ST_OK);
        send_data(8, 8, 1'b0);
        send_data(4, 0, 1'b1);
        send_data(4, 2, 1'b0);
        query(`SBL_ST_OK);
        send_data(1, 0, 1'b0);
        query(`SBL_ST_BADCMD);
        pay = {`SBL_CMD_RUN, 8'h00, 8'h00, 8'h12, 8'h34};
        send_pkt(1'b0, -1);
        check(n_runs, 1);
        pay = {`SBL_CMD_RST};
        send_pkt(1'b0, -1);
        check(n_rsts, 1);
        // A second reset frees the lock; the clocked port is taken and the async one then ignored.
        rst_b <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
        use_ssi = 1'b1;
        pay = {`SBL_CMD_PING};
        send_pkt(1'b0, -1);
        check(tx_on_ssi, 1'b1);
        use_ssi = 1'b0;
        put(8'h03);
        drop();
        repeat (20) @(posedge ref_clk);
        use_ssi = 1'b1;
        query(`SBL_ST_OK);
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
